// *** hw/srsu_barrel.sv ***
// Step-by-step shifter over a left-aligned field of variable width
`timescale 1ns/10ps
module srsu_barrel #(
   parameter int DW = 32,
   parameter int CW = 6
) (
   input wire logic [DW-1:0] opnd_i,
   input wire logic [5:0] width_i,
   input wire logic [CW-1:0] count_i,
   input wire logic left_i,
   input wire srsu_pkg::srsu_kind_t kind_i,
   output logic [DW-1:0] res_o,
   output logic last_o,
   output logic ovf_o
);
   // Bit DW-1 is the sign; field occupies DW-1 down to DW-width
   always_comb begin
      logic [DW-1:0] v;
      logic [DW-1:0] mask;
      logic [4:0] lsb;
      logic fill;
      v = opnd_i;
      lsb = 5'(6'(DW) - width_i);
      mask = {DW{1'b1}} << lsb;
      last_o = 1'b0;
      ovf_o = 1'b0;
      fill = 1'b0;
      // Counts past the width drain a logical field to zero
      for (int i = 0; i < (1 << CW); i++) begin
         if (CW'(i) < count_i) begin
            if (left_i) begin
               if (kind_i == srsu_pkg::SRSU_ARITH && v[DW-1] != v[DW-2]) begin
                  ovf_o = 1'b1;
               end
               last_o = v[DW-1];
               v = (v << 1) & mask;
               if (kind_i == srsu_pkg::SRSU_ROTATE) begin
                  v[lsb] = last_o;
               end
            end else begin
               last_o = v[lsb];
               if (kind_i == srsu_pkg::SRSU_ROTATE) begin
                  fill = last_o;
               end else if (kind_i == srsu_pkg::SRSU_ARITH) begin
                  fill = v[DW-1];
               end else begin
                  fill = 1'b0;
               end
               v = (v >> 1) & mask;
               v[DW-1] = fill;
            end
         end
      end
      res_o = v;
   end
endmodule // srsu_barrel

// *** hw/srsu_ctl_if.sv ***
// Decoded shift setup passed from decoder to core
`timescale 1ns/10ps
interface srsu_ctl_if;
   srsu_pkg::srsu_op_t op;
   logic virt_mode;
   logic gen_left;
   logic [5:0] count_in;
   logic [15:0] acc;
   logic [15:0] ext;
   logic [31:0] long_reg;
   logic [31:0] gen_reg;
   logic [31:0] operand;
   logic [5:0] width;
   logic [5:0] count;
   logic left;
   srsu_pkg::srsu_kind_t kind;
   srsu_pkg::srsu_dst_t dst;
   modport dec (input op, virt_mode, gen_left, count_in, acc, ext, long_reg, gen_reg,
      output operand, width, count, left, kind, dst);
   modport core (output op, virt_mode, gen_left, count_in, acc, ext, long_reg, gen_reg,
      input operand, width, count, left, kind, dst);
endinterface

// *** hw/srsu_decode.sv ***
// Operation decoder: operand alignment, width, kind, direction, count
`timescale 1ns/10ps
module srsu_decode (
   srsu_ctl_if.dec ctl
);
   always_comb begin
      ctl.operand = {ctl.acc, srsu_pkg::HALF_ZERO};
      ctl.width = srsu_pkg::ACC_W;
      ctl.count = ctl.count_in;
      ctl.left = 1'b1;
      ctl.kind = srsu_pkg::SRSU_LOGICAL;
      ctl.dst = srsu_pkg::SRSU_DST_ACC;
      unique case (ctl.op)
         srsu_pkg::SRSU_ACC_LEFT_LOGICAL: begin
         end
         srsu_pkg::SRSU_ACC_LEFT_ROTATE: ctl.kind = srsu_pkg::SRSU_ROTATE;
         srsu_pkg::SRSU_ACC_LEFT_ARITH: ctl.kind = srsu_pkg::SRSU_ARITH;
         srsu_pkg::SRSU_ACC_RIGHT_LOGICAL: ctl.left = 1'b0;
         srsu_pkg::SRSU_ACC_RIGHT_ROTATE: begin
            ctl.left = 1'b0;
            ctl.kind = srsu_pkg::SRSU_ROTATE;
         end
         srsu_pkg::SRSU_ACC_RIGHT_ARITH: begin
            ctl.left = 1'b0;
            ctl.kind = srsu_pkg::SRSU_ARITH;
         end
         srsu_pkg::SRSU_LONG_LEFT_LOGICAL, srsu_pkg::SRSU_LONG_LEFT_ROTATE,
         srsu_pkg::SRSU_LONG_RIGHT_LOGICAL, srsu_pkg::SRSU_LONG_RIGHT_ROTATE: begin
            ctl.operand = ctl.long_reg;
            ctl.width = srsu_pkg::FULL_W;
            ctl.dst = srsu_pkg::SRSU_DST_FULL;
            ctl.left = (ctl.op == srsu_pkg::SRSU_LONG_LEFT_LOGICAL) ||
               (ctl.op == srsu_pkg::SRSU_LONG_LEFT_ROTATE);
            ctl.kind = ((ctl.op == srsu_pkg::SRSU_LONG_LEFT_ROTATE) ||
               (ctl.op == srsu_pkg::SRSU_LONG_RIGHT_ROTATE)) ?
               srsu_pkg::SRSU_ROTATE : srsu_pkg::SRSU_LOGICAL;
         end
         srsu_pkg::SRSU_LONG_LEFT_ARITH, srsu_pkg::SRSU_LONG_RIGHT_ARITH: begin
            ctl.kind = srsu_pkg::SRSU_ARITH;
            ctl.left = (ctl.op == srsu_pkg::SRSU_LONG_LEFT_ARITH);
            if (ctl.virt_mode) begin
               ctl.operand = ctl.long_reg;
               ctl.width = srsu_pkg::FULL_W;
               ctl.dst = srsu_pkg::SRSU_DST_FULL;
            end else begin
               // Extension top bit stays out of the chain
               ctl.operand = {ctl.acc, ctl.ext[14:0], 1'b0};
               ctl.width = srsu_pkg::PAIR_W;
               ctl.dst = srsu_pkg::SRSU_DST_PAIR;
            end
         end
         srsu_pkg::SRSU_GENERAL_ROTATE, srsu_pkg::SRSU_GENERAL_ARITH_SHIFT,
         srsu_pkg::SRSU_GENERAL_LOGICAL_SHIFT: begin
            ctl.operand = ctl.gen_reg;
            ctl.width = srsu_pkg::FULL_W;
            ctl.dst = srsu_pkg::SRSU_DST_FULL;
            ctl.left = ctl.gen_left;
            if (ctl.op == srsu_pkg::SRSU_GENERAL_ROTATE) begin
               ctl.kind = srsu_pkg::SRSU_ROTATE;
            end else if (ctl.op == srsu_pkg::SRSU_GENERAL_ARITH_SHIFT) begin
               ctl.kind = srsu_pkg::SRSU_ARITH;
            end
         end
         srsu_pkg::SRSU_GENERAL_LEFT_ONE, srsu_pkg::SRSU_GENERAL_LEFT_TWO,
         srsu_pkg::SRSU_GENERAL_RIGHT_ONE, srsu_pkg::SRSU_GENERAL_RIGHT_TWO: begin
            ctl.operand = ctl.gen_reg;
            ctl.width = srsu_pkg::FULL_W;
            ctl.dst = srsu_pkg::SRSU_DST_FULL;
            ctl.left = (ctl.op == srsu_pkg::SRSU_GENERAL_LEFT_ONE) ||
               (ctl.op == srsu_pkg::SRSU_GENERAL_LEFT_TWO);
            ctl.count = ((ctl.op == srsu_pkg::SRSU_GENERAL_LEFT_ONE) ||
               (ctl.op == srsu_pkg::SRSU_GENERAL_RIGHT_ONE)) ?
               srsu_pkg::CNT_ONE : srsu_pkg::CNT_TWO;
         end
         srsu_pkg::SRSU_HALF_LEFT_ONE, srsu_pkg::SRSU_HALF_LEFT_TWO,
         srsu_pkg::SRSU_HALF_RIGHT_ONE, srsu_pkg::SRSU_HALF_RIGHT_TWO: begin
            ctl.operand = {ctl.gen_reg[31:16], srsu_pkg::HALF_ZERO};
            ctl.width = srsu_pkg::HALF_W;
            ctl.dst = srsu_pkg::SRSU_DST_HALF;
            ctl.left = (ctl.op == srsu_pkg::SRSU_HALF_LEFT_ONE) ||
               (ctl.op == srsu_pkg::SRSU_HALF_LEFT_TWO);
            ctl.count = ((ctl.op == srsu_pkg::SRSU_HALF_LEFT_ONE) ||
               (ctl.op == srsu_pkg::SRSU_HALF_RIGHT_ONE)) ?
               srsu_pkg::CNT_ONE : srsu_pkg::CNT_TWO;
         end
         default: begin
         end
      endcase
   end
endmodule // srsu_decode

// *** hw/srsu_pkg.sv ***
// Shared constants and types of the shift and rotate unit
package srsu_pkg;
   localparam int DATA_W = 32;
   localparam int CNT_W = 6;
   localparam logic [5:0] ACC_W = 6'h10;
   localparam logic [5:0] PAIR_W = 6'h1F;
   localparam logic [5:0] FULL_W = 6'h20;
   localparam logic [5:0] HALF_W = 6'h10;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam logic [5:0] CNT_TWO = 6'h02;
   localparam logic [5:0] CNT_ZERO = 6'h00;
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;
   localparam logic [15:0] HALF_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      SRSU_LOGICAL = 2'b00,
      SRSU_ARITH = 2'b01,
      SRSU_ROTATE = 2'b10
   } srsu_kind_t;

   typedef enum logic [1:0] {
      SRSU_DST_ACC = 2'b00,
      SRSU_DST_PAIR = 2'b01,
      SRSU_DST_FULL = 2'b10,
      SRSU_DST_HALF = 2'b11
   } srsu_dst_t;

   typedef enum logic [4:0] {
      SRSU_ACC_LEFT_LOGICAL = 5'h00,
      SRSU_ACC_LEFT_ROTATE = 5'h01,
      SRSU_ACC_LEFT_ARITH = 5'h02,
      SRSU_ACC_RIGHT_LOGICAL = 5'h03,
      SRSU_ACC_RIGHT_ROTATE = 5'h04,
      SRSU_ACC_RIGHT_ARITH = 5'h05,
      SRSU_LONG_LEFT_LOGICAL = 5'h06,
      SRSU_LONG_LEFT_ROTATE = 5'h07,
      SRSU_LONG_LEFT_ARITH = 5'h08,
      SRSU_LONG_RIGHT_LOGICAL = 5'h09,
      SRSU_LONG_RIGHT_ROTATE = 5'h0A,
      SRSU_LONG_RIGHT_ARITH = 5'h0B,
      SRSU_GENERAL_ROTATE = 5'h0C,
      SRSU_GENERAL_ARITH_SHIFT = 5'h0D,
      SRSU_GENERAL_LOGICAL_SHIFT = 5'h0E,
      SRSU_GENERAL_LEFT_ONE = 5'h0F,
      SRSU_GENERAL_LEFT_TWO = 5'h10,
      SRSU_GENERAL_RIGHT_ONE = 5'h11,
      SRSU_GENERAL_RIGHT_TWO = 5'h12,
      SRSU_HALF_LEFT_ONE = 5'h13,
      SRSU_HALF_LEFT_TWO = 5'h14,
      SRSU_HALF_RIGHT_ONE = 5'h15,
      SRSU_HALF_RIGHT_TWO = 5'h16
   } srsu_op_t;
endpackage

// *** hw/srsu_shift_unit.sv ***
// Shift and rotate unit: accumulator, pair, long and general registers
// Contract
// - Accumulator shifts: left/right, logical/arithmetic by count
// - Accumulator left rotate: top bit enters bottom
// - Accumulator right rotate: bottom bit enters top
// - Old-mode long left arithmetic: pair, skipping extension top
// - Old-mode long right arithmetic: pair, skipping extension top
// - Virtual mode long ops use 32-bit long
// - General rotate: full register, count and direction
// - General shifts: arithmetic and logical, counted, directed
// - Fixed general left shift by one or two
// - Fixed general right shift by one or two
// - Fixed halfword left shifts upper half only
// - Fixed halfword right shifts upper half only
// - Logical: zero fill, carry/link get last out
// - Arithmetic right sign fill; left zero fill
// - Sign change on arithmetic left raises exception
// - Rotate: carry/link hold last rotated bit
`timescale 1ns/10ps
module srsu_shift_unit (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire srsu_pkg::srsu_op_t op_i,
   input wire logic virt_mode_i,
   input wire logic gen_left_i,
   input wire logic [5:0] count_i,
   input wire logic [15:0] acc_i,
   input wire logic [15:0] ext_i,
   input wire logic [31:0] long_i,
   input wire logic [31:0] gen_i,
   output logic done_o,
   output logic [31:0] result_o,
   output srsu_pkg::srsu_dst_t dest_o,
   output logic carry_flag_o,
   output logic link_o,
   output logic int_exc_o
);
   srsu_ctl_if ctl ();

   logic [31:0] sh_res;
   logic sh_last;
   logic sh_ovf;
   logic [31:0] result_q;
   logic [31:0] result_d;
   srsu_pkg::srsu_dst_t dest_q;
   srsu_pkg::srsu_dst_t dest_d;
   logic done_q;
   logic done_d;
   logic carry_q;
   logic carry_d;
   logic link_q;
   logic link_d;
   logic exc_q;
   logic exc_d;

   assign ctl.op = op_i;
   assign ctl.virt_mode = virt_mode_i;
   assign ctl.gen_left = gen_left_i;
   assign ctl.count_in = count_i;
   assign ctl.acc = acc_i;
   assign ctl.ext = ext_i;
   assign ctl.long_reg = long_i;
   assign ctl.gen_reg = gen_i;

   srsu_decode u_decode (
      .ctl(ctl)
   );

   srsu_barrel #(
      .DW(srsu_pkg::DATA_W),
      .CW(srsu_pkg::CNT_W)
   ) u_barrel (
      .opnd_i(ctl.operand),
      .width_i(ctl.width),
      .count_i(ctl.count),
      .left_i(ctl.left),
      .kind_i(ctl.kind),
      .res_o(sh_res),
      .last_o(sh_last),
      .ovf_o(sh_ovf)
   );

   // Result packing and flag update, one cycle per request
   always_comb begin
      result_d = result_q;
      dest_d = dest_q;
      carry_d = carry_q;
      link_d = link_q;
      done_d = 1'b0;
      exc_d = 1'b0;
      if (start_i) begin
         done_d = 1'b1;
         dest_d = ctl.dst;
         unique case (ctl.dst)
            srsu_pkg::SRSU_DST_ACC: result_d = {srsu_pkg::HALF_ZERO, sh_res[31:16]};
            srsu_pkg::SRSU_DST_PAIR: result_d = {sh_res[31:16], ext_i[15], sh_res[15:1]};
            srsu_pkg::SRSU_DST_FULL: result_d = sh_res;
            srsu_pkg::SRSU_DST_HALF: result_d = {sh_res[31:16], gen_i[15:0]};
         endcase
         // A zero count moves no bit, so flags keep their value
         if (ctl.count != srsu_pkg::CNT_ZERO) begin
            carry_d = sh_last;
            link_d = sh_last;
         end
         exc_d = sh_ovf;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_q <= srsu_pkg::RESULT_RST;
         dest_q <= srsu_pkg::SRSU_DST_ACC;
         done_q <= 1'b0;
         carry_q <= 1'b0;
         link_q <= 1'b0;
         exc_q <= 1'b0;
      end else begin
         result_q <= result_d;
         dest_q <= dest_d;
         done_q <= done_d;
         carry_q <= carry_d;
         link_q <= link_d;
         exc_q <= exc_d;
      end
   end

   assign done_o = done_q;
   assign result_o = result_q;
   assign dest_o = dest_q;
   assign carry_flag_o = carry_q;
   assign link_o = link_q;
   assign int_exc_o = exc_q;

   // Checks below tie each answer to the request one edge earlier
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_req(srsu_pkg::srsu_op_t o, logic [5:0] c);
      start_i && op_i == o && count_i == c;
   endsequence

   a_acc_left_logical: assert property (
      s_req(srsu_pkg::SRSU_ACC_LEFT_LOGICAL, srsu_pkg::CNT_ONE) |=>
      done_o && result_o[15:0] == {$past(acc_i[14:0]), 1'b0} &&
      carry_flag_o == $past(acc_i[15]))
      else $error("accumulator left logical shift wrong");

   a_acc_rot_left: assert property (
      s_req(srsu_pkg::SRSU_ACC_LEFT_ROTATE, srsu_pkg::CNT_ONE) |=>
      result_o[15:0] == {$past(acc_i[14:0]), $past(acc_i[15])})
      else $error("accumulator left rotate wrong");

   a_acc_rot_right: assert property (
      s_req(srsu_pkg::SRSU_ACC_RIGHT_ROTATE, srsu_pkg::CNT_TWO) |=>
      result_o[15:0] == {$past(acc_i[1:0]), $past(acc_i[15:2])})
      else $error("accumulator right rotate wrong");

   a_pair_left_skip: assert property (
      start_i && op_i == srsu_pkg::SRSU_LONG_LEFT_ARITH && !virt_mode_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(acc_i[14:0]), $past(ext_i[14]), $past(ext_i[15]),
      $past(ext_i[13:0]), 1'b0})
      else $error("pair left shift did not skip extension top bit");

   a_pair_right_skip: assert property (
      start_i && op_i == srsu_pkg::SRSU_LONG_RIGHT_ARITH && !virt_mode_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(acc_i[15]), $past(acc_i[15:1]), $past(ext_i[15]),
      $past(acc_i[0]), $past(ext_i[14:1])})
      else $error("pair right shift did not skip extension top bit");

   a_long_virtual: assert property (
      start_i && op_i == srsu_pkg::SRSU_LONG_RIGHT_LOGICAL && count_i == srsu_pkg::CNT_TWO
      |=> result_o == {2'b00, $past(long_i[31:2])} && link_o == $past(long_i[1]))
      else $error("long right logical shift wrong");

   a_gen_rotate: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_ROTATE && !gen_left_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(gen_i[0]), $past(gen_i[31:1])} && carry_flag_o == result_o[31])
      else $error("general right rotate wrong");

   a_gen_arith_right: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_ARITH_SHIFT && !gen_left_i &&
      count_i == srsu_pkg::CNT_TWO |=>
      result_o == {{2{$past(gen_i[31])}}, $past(gen_i[31:2])} && link_o == $past(gen_i[1]))
      else $error("general arithmetic right shift wrong");

   a_fixed_left_two: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_LEFT_TWO |=>
      result_o == {$past(gen_i[29:0]), 2'b00})
      else $error("fixed left two shift wrong");

   a_fixed_right_one: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_RIGHT_ONE |=>
      result_o == {1'b0, $past(gen_i[31:1])})
      else $error("fixed right one shift wrong");

   a_half_left_keep: assert property (
      start_i && op_i == srsu_pkg::SRSU_HALF_LEFT_ONE |=>
      result_o == {$past(gen_i[30:16]), 1'b0, $past(gen_i[15:0])})
      else $error("halfword left shift touched lower half");

   a_half_right_keep: assert property (
      start_i && op_i == srsu_pkg::SRSU_HALF_RIGHT_TWO |=>
      result_o == {2'b00, $past(gen_i[31:18]), $past(gen_i[15:0])})
      else $error("halfword right shift touched lower half");

   a_overflow_exc: assert property (
      s_req(srsu_pkg::SRSU_ACC_LEFT_ARITH, srsu_pkg::CNT_ONE) |=>
      int_exc_o == ($past(acc_i[15]) != $past(acc_i[14])) ##1 !int_exc_o || done_o)
      else $error("integer exception not tied to sign change");

   a_zero_count: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_LOGICAL_SHIFT &&
      count_i == srsu_pkg::CNT_ZERO |=>
      result_o == $past(gen_i) && $stable(carry_flag_o))
      else $error("zero count changed operand or flags");

   a_big_count: assert property (
      start_i && op_i == srsu_pkg::SRSU_ACC_RIGHT_LOGICAL && count_i >= srsu_pkg::ACC_W
      |=> result_o == srsu_pkg::RESULT_RST)
      else $error("oversize logical count did not clear");

   a_done_pulse: assert property (
      !start_i |=> !done_o && !int_exc_o)
      else $error("done or exception without a request");

   a_acc_right_logical: assert property (
      s_req(srsu_pkg::SRSU_ACC_RIGHT_LOGICAL, srsu_pkg::CNT_ONE) |=>
      result_o == {srsu_pkg::HALF_ZERO, 1'b0, $past(acc_i[15:1])} &&
      carry_flag_o == $past(acc_i[0]))
      else $error("accumulator right logical shift wrong");

   a_acc_right_arith: assert property (
      s_req(srsu_pkg::SRSU_ACC_RIGHT_ARITH, srsu_pkg::CNT_TWO) |=>
      result_o[15:0] == {{2{$past(acc_i[15])}}, $past(acc_i[15:2])} &&
      link_o == $past(acc_i[1]))
      else $error("accumulator right arithmetic shift wrong");

   a_acc_left_arith: assert property (
      s_req(srsu_pkg::SRSU_ACC_LEFT_ARITH, srsu_pkg::CNT_TWO) |=>
      result_o[15:0] == {$past(acc_i[13:0]), 2'b00} &&
      carry_flag_o == $past(acc_i[14]))
      else $error("accumulator left arithmetic shift did not zero fill");

   a_acc_rot_full: assert property (
      s_req(srsu_pkg::SRSU_ACC_LEFT_ROTATE, srsu_pkg::ACC_W) |=>
      result_o[15:0] == $past(acc_i) &&
      carry_flag_o == $past(acc_i[0]))
      else $error("accumulator rotate by full width not identity");

   a_long_rot_left: assert property (
      s_req(srsu_pkg::SRSU_LONG_LEFT_ROTATE, srsu_pkg::CNT_ONE) |=>
      result_o == {$past(long_i[30:0]), $past(long_i[31])} &&
      dest_o == srsu_pkg::SRSU_DST_FULL)
      else $error("long left rotate wrong");

   a_long_virt_arith: assert property (
      start_i && op_i == srsu_pkg::SRSU_LONG_LEFT_ARITH && virt_mode_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(long_i[30:0]), 1'b0} &&
      int_exc_o == ($past(long_i[31]) != $past(long_i[30])))
      else $error("virtual mode long left arithmetic shift wrong");

   a_gen_logical_left: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_LOGICAL_SHIFT && gen_left_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(gen_i[30:0]), 1'b0} &&
      carry_flag_o == $past(gen_i[31]))
      else $error("general logical left shift wrong");

   a_fixed_left_one: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_LEFT_ONE |=>
      result_o == {$past(gen_i[30:0]), 1'b0} &&
      link_o == $past(gen_i[31]))
      else $error("fixed left one shift wrong");

   a_fixed_right_two: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_RIGHT_TWO |=>
      result_o == {2'b00, $past(gen_i[31:2])} &&
      carry_flag_o == $past(gen_i[1]))
      else $error("fixed right two shift wrong");

   a_half_left_two: assert property (
      start_i && op_i == srsu_pkg::SRSU_HALF_LEFT_TWO |=>
      result_o == {$past(gen_i[29:16]), 2'b00, $past(gen_i[15:0])} &&
      dest_o == srsu_pkg::SRSU_DST_HALF)
      else $error("halfword left two shift wrong");

   a_half_right_one: assert property (
      start_i && op_i == srsu_pkg::SRSU_HALF_RIGHT_ONE |=>
      result_o == {1'b0, $past(gen_i[31:17]), $past(gen_i[15:0])} &&
      carry_flag_o == $past(gen_i[16]))
      else $error("halfword right one shift wrong");

   a_gen_rot_left: assert property (
      start_i && op_i == srsu_pkg::SRSU_GENERAL_ROTATE && gen_left_i &&
      count_i == srsu_pkg::CNT_ONE |=>
      result_o == {$past(gen_i[30:0]), $past(gen_i[31])} &&
      carry_flag_o == $past(gen_i[31]) && link_o == $past(gen_i[31]))
      else $error("general left rotate flags wrong");
endmodule // srsu_shift_unit

// *** testbench/srsu_dec_model.sv ***
// Request source standing in for the instruction decoder and register file
`timescale 1ns/10ps
module srsu_dec_model (
   input wire logic mclk_i,
   output logic start_o,
   output srsu_pkg::srsu_op_t op_o,
   output logic virt_mode_o,
   output logic gen_left_o,
   output logic [5:0] count_o,
   output logic [15:0] acc_o,
   output logic [15:0] ext_o,
   output logic [31:0] long_o,
   output logic [31:0] gen_o
);
   initial begin
      start_o = 1'b0;
      op_o = srsu_pkg::SRSU_ACC_LEFT_LOGICAL;
      {virt_mode_o, gen_left_o, count_o, acc_o, ext_o, long_o, gen_o} = '0;
   end

   // Held for one edge; back-to-back calls keep start high
   task automatic issue(input srsu_pkg::srsu_op_t op, input logic vm, input logic gl,
      input logic [5:0] cnt, input logic [15:0] a, input logic [15:0] e,
      input logic [31:0] l, input logic [31:0] g);
      start_o = 1'b1;
      op_o = op;
      virt_mode_o = vm;
      gen_left_o = gl;
      count_o = cnt;
      {acc_o, ext_o, long_o, gen_o} = {a, e, l, g};
      @(posedge mclk_i);
      #2;
   endtask

   // Operands no longer valid: show their inverse so stale values never pass
   task automatic idle();
      start_o = 1'b0;
      {count_o, acc_o, ext_o, long_o, gen_o} = ~{count_o, acc_o, ext_o, long_o, gen_o};
      @(posedge mclk_i);
      #2;
   endtask
endmodule // srsu_dec_model

// *** testbench/srsu_shift_unit_bench.sv ***
// Self-checking bench of the shift and rotate unit
`timescale 1ns/10ps
module srsu_shift_unit_bench;
   logic mclk_i, rst_n_i, start_i, virt_mode_i, gen_left_i;
   srsu_pkg::srsu_op_t op_i;
   logic [5:0] count_i;
   logic [15:0] acc_i, ext_i;
   logic [31:0] long_i, gen_i, result_o, e_res;
   logic done_o, carry_flag_o, link_o, int_exc_o, e_cy, e_exc, e_done;
   srsu_pkg::srsu_dst_t dest_o;
   int e_lay, errors, n_tests, seed, i, j;
   int codes[23] = '{1, 21, 11, 0, 20, 10, 101, 121, 111, 100, 120, 110,
      222, 212, 202, 301, 301, 300, 300, 401, 401, 400, 400};
   logic [5:0] cnts[9] = '{6'h00, 6'h01, 6'h02, 6'h0F, 6'h10, 6'h11, 6'h1F, 6'h20, 6'h3F};

   srsu_dec_model srsu_dec_model_i (.mclk_i(mclk_i), .start_o(start_i), .op_o(op_i),
      .virt_mode_o(virt_mode_i), .gen_left_o(gen_left_i), .count_o(count_i),
      .acc_o(acc_i), .ext_o(ext_i), .long_o(long_i), .gen_o(gen_i));
   srsu_shift_unit srsu_shift_unit_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i),
      .op_i(op_i), .virt_mode_i(virt_mode_i), .gen_left_i(gen_left_i), .count_i(count_i),
      .acc_i(acc_i), .ext_i(ext_i), .long_i(long_i), .gen_i(gen_i), .done_o(done_o),
      .result_o(result_o), .dest_o(dest_o), .carry_flag_o(carry_flag_o), .link_o(link_o),
      .int_exc_o(int_exc_o));

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Step-by-step model: a code is group*100 + kind*10 + direction (2 = from gen_left)
   task automatic model();
      int c, grp, k, w, n;
      logic lf, o, s;
      logic [32:0] v;
      c = codes[op_i];
      grp = c / 100;
      k = (c / 10) % 10;
      lf = (c % 10 == 2) ? gen_left_i : logic'(c % 10);
      n = (grp >= 3) ? ((int'(op_i) - 15) % 2) + 1 : int'(count_i);
      w = (grp == 0 || grp == 4) ? 16 : 32;
      v = (grp == 0) ? {17'h00000, acc_i} : (grp == 1) ? {1'b0, long_i} : {1'b0, gen_i};
      e_lay = (grp == 0) ? 0 : (grp == 4) ? 3 : 2;
      if (grp == 4) v = {17'h00000, gen_i[31:16]};
      if (grp == 1 && k == 1 && !virt_mode_i) begin
         w = 31;
         v = {2'b00, acc_i, ext_i[14:0]};
         e_lay = 1;
      end
      e_exc = 1'b0;
      for (int t = 0; t < n; t++) begin
         s = v[w-1];
         if (lf) begin
            o = v[w-1];
            v = v << 1;
            v[0] = (k == 2) ? o : 1'b0;
            v[w] = 1'b0;
            if (k == 1 && v[w-1] != s) e_exc = 1'b1;
         end else begin
            o = v[0];
            v = v >> 1;
            v[w-1] = (k == 2) ? o : (k == 1) ? s : 1'b0;
         end
         e_cy = o;
      end
      case (e_lay)
         0: e_res = {16'h0000, v[15:0]};
         1: e_res = {v[30:15], ext_i[15], v[14:0]};
         2: e_res = v[31:0];
         default: e_res = {v[15:0], gen_i[15:0]};
      endcase
   endtask

   // Compared at every edge: pulse after a taken request, levels held otherwise
   always @(posedge mclk_i) begin
      e_done = rst_n_i && start_i;
      if (!rst_n_i) begin
         {e_res, e_cy, e_lay} = '0;
      end
      if (e_done) model();
      #1;
      chk("done", {31'h0, e_done}, {31'h0, done_o});
      chk("result", e_res, result_o);
      chk("dest", e_lay, {30'h0, dest_o});
      chk("carry", {31'h0, e_cy}, {31'h0, carry_flag_o});
      chk("link", {31'h0, e_cy}, {31'h0, link_o});
      chk("exception", {31'h0, e_done & e_exc}, {31'h0, int_exc_o});
   end

   task automatic rnd_issue(input srsu_pkg::srsu_op_t op, input logic [5:0] cnt);
      logic [31:0] r1, r2, r3, r4;
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      r4 = $random(seed);
      srsu_dec_model_i.issue(op, r4[0], r4[1], cnt, r1[15:0], r1[31:16], r2, r3);
   endtask

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #(5000 * 25);
      errors++;
      end_of_test();
   end

   initial begin
      {errors, n_tests} = '0;
      seed = 30160;
      rst_n_i = 1'b0;
      repeat (16) @(posedge mclk_i);
      #2;
      rst_n_i = 1'b1;
      srsu_dec_model_i.issue(srsu_pkg::SRSU_ACC_LEFT_ROTATE, 1'b0, 1'b0, 6'h01, 16'h8001,
         16'h0000, 32'h0, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_ACC_RIGHT_ROTATE, 1'b0, 1'b0, 6'h01, 16'h0001,
         16'h0000, 32'h0, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_ACC_LEFT_ARITH, 1'b0, 1'b0, 6'h01, 16'h4000,
         16'h0000, 32'h0, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_LONG_LEFT_ARITH, 1'b0, 1'b0, 6'h01, 16'hC001,
         16'h4002, 32'h0, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_LONG_RIGHT_ARITH, 1'b0, 1'b0, 6'h01, 16'h8001,
         16'hC002, 32'h0, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_LONG_LEFT_ARITH, 1'b1, 1'b0, 6'h01, 16'h0,
         16'h0, 32'h4000_0001, 32'h0);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_GENERAL_ROTATE, 1'b0, 1'b0, 6'h01, 16'h0,
         16'h0, 32'h0, 32'h8000_0001);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_GENERAL_ARITH_SHIFT, 1'b0, 1'b0, 6'h02, 16'h0,
         16'h0, 32'h0, 32'h8000_0006);
      srsu_dec_model_i.issue(srsu_pkg::SRSU_GENERAL_LOGICAL_SHIFT, 1'b0, 1'b1, 6'h01, 16'h0,
         16'h0, 32'h0, 32'hC000_0000);
      srsu_dec_model_i.idle();
      $display("Test directed cases done");
      // Every op at every boundary count, back to back
      for (j = 0; j < 9; j++) begin
         for (i = 0; i < 23; i++) rnd_issue(srsu_pkg::srsu_op_t'(i), cnts[j]);
      end
      srsu_dec_model_i.idle();
      $display("Test op and count sweep done");
      for (i = 0; i < 400; i++) begin
         j = $unsigned($random(seed)) % 32;
         if (j < 23) rnd_issue(srsu_pkg::srsu_op_t'(j), 6'($random(seed)));
         else srsu_dec_model_i.idle();
      end
      srsu_dec_model_i.idle();
      $display("Test random traffic done");
      rnd_issue(srsu_pkg::SRSU_GENERAL_ROTATE, 6'h05);
      rst_n_i = 1'b0;
      srsu_dec_model_i.idle();
      srsu_dec_model_i.idle();
      rst_n_i = 1'b1;
      rnd_issue(srsu_pkg::SRSU_LONG_RIGHT_ARITH, 6'h00);
      srsu_dec_model_i.idle();
      srsu_dec_model_i.idle();
      $display("Test mid-run reset done");
      end_of_test();
   end
endmodule // srsu_shift_unit_bench
